// File: rtl/ssa_defines.svh
`ifndef SSA_DEFINES_SVH
`define SSA_DEFINES_SVH

// ****************************************************************
// register offsets
// ****************************************************************
`define SSA_ADDR_W 4
`define SSA_OFS_SEC_CFG 4'h0
`define SSA_OFS_NS_ACC 4'h1
`define SSA_OFS_ITCM_ACC 4'h2
`define SSA_OFS_DTCM_ACC 4'h3
`define SSA_OFS_DBG_STAT 4'h4
`define SSA_OFS_MODE 4'h5

// ****************************************************************
// field positions
// ****************************************************************
`define SSA_CFG_WORLD 0
`define SSA_CFG_IRQ_MON 1
`define SSA_CFG_FIQ_MON 2
`define SSA_CFG_EA_MON 3
`define SSA_CFG_FIQ_LOCK 4
`define SSA_CFG_ABT_LOCK 5
`define SSA_CFG_W 6
`define SSA_NSACC_DMA 18
`define SSA_TCM_ACC_BIT 0
`define SSA_DBG_WORLD 18

// ****************************************************************
// reset values and encodings
// ****************************************************************
`define SSA_CFG_RST 6'h00
`define SSA_DMA_RST 1'h0
`define SSA_TCM_RST 1'h0
`define SSA_MASK_RST 1'h0
`define SSA_SECURE 1'h0
`define SSA_NONSECURE 1'h1
`define SSA_MODE_W 5
`define SSA_MODE_USR 5'h10
`define SSA_MODE_FIQ 5'h11
`define SSA_MODE_IRQ 5'h12
`define SSA_MODE_SVC 5'h13
`define SSA_MODE_MON 5'h16
`define SSA_MODE_ABT 5'h17
`define SSA_MODE_UND 5'h1B
`define SSA_MODE_SYS 5'h1F
`define SSA_ZERO32 32'h00000000

`endif

// File: rtl/ssa_pkg.sv
`include "ssa_defines.svh"

package ssa_pkg;

    typedef logic [`SSA_MODE_W-1:0] ssa_mode_t;
    typedef logic [`SSA_ADDR_W-1:0] ssa_addr_t;
    typedef logic [31:0] ssa_word_t;

endpackage : ssa_pkg

// File: rtl/ssa_top.sv
// Function
// - every security bit: zero means Secure, one means Non-secure
// - world is Secure if world-select bit is zero or mode is Monitor
// - core request security is world; dma request uses dma security bit
// - location: mmu off request; secure mmu on descriptor; else Non-secure
// - world-select bit at config bit 0 picks copies in Monitor mode
// - dma security bit held at bit 18 of non-secure access register
// - tcm access security bits held at bit 0 of each tcm register
// - reset gives Supervisor mode, Secure world, unrestricted memory access
// - config bits 1..3 route irq, fiq, aborts to Monitor mode
// - config bits 5..4 lock abort and fiq mask writes when Non-secure
// - config writes accepted only from Secure privileged modes
// - world indication visible at bit 18 of debug status register
// - software banked register access selects copy by world-select bit
// - hardware lookups select bank by request security and dma bit
// - page-table security bit ignored for Non-secure translations
// - tlb entries tagged with world that created them
// - cache lines stored with security tag
// - bus transactions carry security identifier
// - Secure memory accessed only from Secure world
// - Non-secure mmu enable copy has no effect on location security
// - walk location security is request security of missing access
// - cache hit needs stored tag equal to location security
//
// The plain strobed port and the address map were chosen for this implementation.
`include "ssa_defines.svh"

module ssa_top (
    input wire logic clk,
    input wire logic nrst,
    // register port
    input wire ssa_pkg::ssa_addr_t reg_addr,
    input wire ssa_pkg::ssa_word_t reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output ssa_pkg::ssa_word_t reg_rdata,
    output logic reg_wr_refused,
    // mode tracking
    input wire logic mode_load,
    input wire ssa_pkg::ssa_mode_t mode_next,
    output ssa_pkg::ssa_mode_t cur_mode,
    output logic exec_world,
    output logic world_select_bit,
    // memory request attributes
    input wire logic req_is_dma,
    input wire logic req_is_walk,
    input wire logic walk_miss_security,
    input wire logic mmu_en_secure,
    input wire logic pagetable_security_bit,
    output logic request_security,
    output logic location_security,
    // banked system register selection
    output logic sw_bank_select,
    output logic hw_bank_select,
    // tlb and cache tagging
    input wire logic tlb_fill,
    output logic tlb_entry_world_id,
    output logic tlb_fill_out,
    output logic cache_line_world_tag,
    input wire logic cache_addr_match,
    input wire logic cache_stored_tag,
    output logic cache_hit,
    // external bus
    input wire logic bus_req,
    input wire logic region_is_secure,
    output logic bus_security_signal,
    output logic bus_grant,
    output logic access_denied,
    // tcm and dma security
    output logic dma_security_bit,
    output logic itcm_access_security,
    output logic dtcm_access_security,
    // exception routing
    input wire logic irq_req,
    input wire logic fiq_req,
    input wire logic precise_abort,
    input wire logic imprecise_abort,
    output logic irq_to_monitor,
    output logic fiq_to_monitor,
    output logic precise_abort_to_monitor,
    output logic imprecise_abort_to_monitor,
    // status mask write filter
    input wire logic mask_wr,
    input wire logic async_abort_mask_in,
    input wire logic fast_irq_mask_in,
    output logic async_abort_mask,
    output logic fast_irq_mask
);

    // ****************************************************************
    // state
    // ****************************************************************
    logic [`SSA_CFG_W-1:0] secure_config_reg;
    logic nonsecure_access_ctrl_reg;
    logic itcm_access_ctrl_reg;
    logic dtcm_access_ctrl_reg;
    ssa_pkg::ssa_mode_t mode_q;
    ssa_pkg::ssa_word_t next_rdata;

    function automatic logic is_privileged(input ssa_pkg::ssa_mode_t m);
        is_privileged = (m != `SSA_MODE_USR);
    endfunction : is_privileged

    function automatic logic is_monitor(input ssa_pkg::ssa_mode_t m);
        is_monitor = (m == `SSA_MODE_MON);
    endfunction : is_monitor

    function automatic logic is_secure(input logic b);
        is_secure = (b == `SSA_SECURE);
    endfunction : is_secure

    function automatic logic pick_bit(input logic sel,
        input logic when_set, input logic when_clear);
        pick_bit = sel ? when_set : when_clear;
    endfunction : pick_bit

    function automatic logic secure_lock(input logic nonsec,
        input logic lock_bit);
        secure_lock = nonsec && lock_bit;
    endfunction : secure_lock

    function automatic logic route_to_mon(input logic req,
        input logic enable);
        route_to_mon = req && enable;
    endfunction : route_to_mon

    function automatic ssa_pkg::ssa_word_t place_bit(input logic b,
        input int unsigned pos);
        place_bit = `SSA_ZERO32;
        place_bit[pos] = b;
    endfunction : place_bit

    // ****************************************************************
    // world derivation
    // ****************************************************************
    wire logic world_bit = secure_config_reg[`SSA_CFG_WORLD];
    wire logic in_monitor = is_monitor(mode_q);
    // combinational from live mode and config, no stale state
    wire logic world = (world_bit == `SSA_SECURE) || in_monitor ?
        `SSA_SECURE : `SSA_NONSECURE;
    wire logic secure_priv = (world == `SSA_SECURE) &&
        is_privileged(mode_q);

    assign cur_mode = mode_q;
    assign exec_world = world;
    assign world_select_bit = world_bit;

    // ****************************************************************
    // request and location security
    // ****************************************************************
    wire logic core_req_sec = req_is_walk ? walk_miss_security : world;
    wire logic req_sec = req_is_dma ? nonsecure_access_ctrl_reg :
        core_req_sec;
    // descriptor bit trusted only for Secure requests
    wire logic desc_used = is_secure(req_sec) ?
        pagetable_security_bit : `SSA_NONSECURE;
    // walks take request security of the missing access
    wire logic loc_sec = req_is_walk ? walk_miss_security :
        (!mmu_en_secure ? req_sec : desc_used);

    assign request_security = req_sec;
    assign location_security = loc_sec;

    // ****************************************************************
    // banked register selection
    // ****************************************************************
    assign sw_bank_select = world_bit;
    assign hw_bank_select = req_is_dma ? nonsecure_access_ctrl_reg :
        req_sec;

    // ****************************************************************
    // tlb and cache tags
    // ****************************************************************
    assign tlb_entry_world_id = req_sec;
    assign tlb_fill_out = tlb_fill;
    assign cache_line_world_tag = loc_sec;
    assign cache_hit = cache_addr_match &&
        (cache_stored_tag == loc_sec);

    // ****************************************************************
    // external bus
    // ****************************************************************
    wire logic deny = bus_req && region_is_secure &&
        world == `SSA_NONSECURE;
    assign bus_security_signal = loc_sec;
    assign bus_grant = bus_req && !deny;
    assign access_denied = deny;

    // ****************************************************************
    // tcm and dma bits
    // ****************************************************************
    assign dma_security_bit = nonsecure_access_ctrl_reg;
    assign itcm_access_security = itcm_access_ctrl_reg;
    assign dtcm_access_security = dtcm_access_ctrl_reg;

    // ****************************************************************
    // exception routing
    // ****************************************************************
    wire logic irq_route = secure_config_reg[`SSA_CFG_IRQ_MON];
    wire logic fiq_route = secure_config_reg[`SSA_CFG_FIQ_MON];
    wire logic ext_abort_route = secure_config_reg[`SSA_CFG_EA_MON];

    assign irq_to_monitor = route_to_mon(irq_req, irq_route);
    assign fiq_to_monitor = route_to_mon(fiq_req, fiq_route);
    assign precise_abort_to_monitor =
        route_to_mon(precise_abort, ext_abort_route);
    assign imprecise_abort_to_monitor =
        route_to_mon(imprecise_abort, ext_abort_route);

    // ****************************************************************
    // mask write filter
    // ****************************************************************
    wire logic ns_world = !is_secure(world);
    wire logic abt_lock_bit = secure_config_reg[`SSA_CFG_ABT_LOCK];
    wire logic fiq_lock_bit = secure_config_reg[`SSA_CFG_FIQ_LOCK];
    wire logic abt_lock = secure_lock(ns_world, abt_lock_bit);
    wire logic fiq_lock = secure_lock(ns_world, fiq_lock_bit);
    wire logic abt_mask_we = mask_wr && !abt_lock;
    wire logic fiq_mask_we = mask_wr && !fiq_lock;
    wire logic next_abt_mask =
        pick_bit(abt_mask_we, async_abort_mask_in, async_abort_mask);
    wire logic next_fiq_mask =
        pick_bit(fiq_mask_we, fast_irq_mask_in, fast_irq_mask);

    // ****************************************************************
    // register decode
    // ****************************************************************
    wire logic sel_cfg = (reg_addr == `SSA_OFS_SEC_CFG);
    wire logic sel_nsacc = (reg_addr == `SSA_OFS_NS_ACC);
    wire logic sel_itcm = (reg_addr == `SSA_OFS_ITCM_ACC);
    wire logic sel_dtcm = (reg_addr == `SSA_OFS_DTCM_ACC);
    wire logic sel_dbg = (reg_addr == `SSA_OFS_DBG_STAT);
    wire logic sel_mode = (reg_addr == `SSA_OFS_MODE);
    wire logic sel_ctrl = sel_cfg || sel_nsacc || sel_itcm || sel_dtcm;

    // ****************************************************************
    // write enables
    // ****************************************************************
    wire logic wr_ok = reg_wr && secure_priv;
    wire logic wr_bad = reg_wr && sel_ctrl && !secure_priv;
    wire logic we_cfg = wr_ok && sel_cfg;
    wire logic we_nsacc = wr_ok && sel_nsacc;
    wire logic we_itcm = wr_ok && sel_itcm;
    wire logic we_dtcm = wr_ok && sel_dtcm;

    // ****************************************************************
    // next register values
    // ****************************************************************
    wire logic [`SSA_CFG_W-1:0] next_cfg = we_cfg ?
        reg_wdata[`SSA_CFG_W-1:0] : secure_config_reg;
    wire logic next_nsacc = pick_bit(we_nsacc,
        reg_wdata[`SSA_NSACC_DMA], nonsecure_access_ctrl_reg);
    wire logic next_itcm = pick_bit(we_itcm,
        reg_wdata[`SSA_TCM_ACC_BIT], itcm_access_ctrl_reg);
    wire logic next_dtcm = pick_bit(we_dtcm,
        reg_wdata[`SSA_TCM_ACC_BIT], dtcm_access_ctrl_reg);
    wire ssa_pkg::ssa_mode_t next_mode = mode_load ? mode_next : mode_q;

    // ****************************************************************
    // read data
    // ****************************************************************
    wire ssa_pkg::ssa_word_t rd_nsacc =
        place_bit(nonsecure_access_ctrl_reg, `SSA_NSACC_DMA);
    wire ssa_pkg::ssa_word_t rd_itcm =
        place_bit(itcm_access_ctrl_reg, `SSA_TCM_ACC_BIT);
    wire ssa_pkg::ssa_word_t rd_dtcm =
        place_bit(dtcm_access_ctrl_reg, `SSA_TCM_ACC_BIT);
    wire ssa_pkg::ssa_word_t rd_dbg = place_bit(world, `SSA_DBG_WORLD);

    always_comb begin
        next_rdata = `SSA_ZERO32;
        if (sel_cfg) begin
            next_rdata[`SSA_CFG_W-1:0] = secure_config_reg;
        end else if (sel_nsacc) begin
            next_rdata = rd_nsacc;
        end else if (sel_itcm) begin
            next_rdata = rd_itcm;
        end else if (sel_dtcm) begin
            next_rdata = rd_dtcm;
        end else if (sel_dbg) begin
            next_rdata = rd_dbg;
        end else if (sel_mode) begin
            next_rdata[`SSA_MODE_W-1:0] = mode_q;
        end
    end

    wire ssa_pkg::ssa_word_t next_rd_word = reg_rd ? next_rdata :
        `SSA_ZERO32;

    // ****************************************************************
    // config and access registers
    // ****************************************************************
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            secure_config_reg <= `SSA_CFG_RST;
        end else begin
            secure_config_reg <= next_cfg;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            nonsecure_access_ctrl_reg <= `SSA_DMA_RST;
        end else begin
            nonsecure_access_ctrl_reg <= next_nsacc;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            itcm_access_ctrl_reg <= `SSA_TCM_RST;
        end else begin
            itcm_access_ctrl_reg <= next_itcm;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            dtcm_access_ctrl_reg <= `SSA_TCM_RST;
        end else begin
            dtcm_access_ctrl_reg <= next_dtcm;
        end
    end

    // ****************************************************************
    // mode register
    // ****************************************************************
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            mode_q <= `SSA_MODE_SVC;
        end else begin
            mode_q <= next_mode;
        end
    end

    // ****************************************************************
    // mask registers
    // ****************************************************************
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            async_abort_mask <= `SSA_MASK_RST;
        end else begin
            async_abort_mask <= next_abt_mask;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            fast_irq_mask <= `SSA_MASK_RST;
        end else begin
            fast_irq_mask <= next_fiq_mask;
        end
    end

    // ****************************************************************
    // read port registers
    // ****************************************************************
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            reg_rdata <= `SSA_ZERO32;
        end else begin
            reg_rdata <= next_rd_word;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            reg_wr_refused <= `SSA_MASK_RST;
        end else begin
            reg_wr_refused <= wr_bad;
        end
    end

endmodule : ssa_top

// File: test/ssa_bus_model.sv
module ssa_bus_model (
    input wire logic clk,
    input wire logic bus_grant,
    input wire logic bus_security_signal,
    input wire logic region_is_secure,
    input wire logic exec_world,
    output logic leak
);
    timeunit 1ns;
    timeprecision 1ps;
    // leak flagged when a grant reaches a secure region in the Non-secure world
    initial leak = 1'h0;
    always @(posedge clk) begin
        if (bus_grant && region_is_secure && exec_world) begin
            leak <= 1'h1;
        end
    end
endmodule : ssa_bus_model

// File: test/ssa_props.sv
`include "ssa_defines.svh"

module ssa_props (
    input wire logic clk,
    input wire logic nrst,
    input wire ssa_pkg::ssa_addr_t reg_addr,
    input wire logic reg_wr,
    input wire logic reg_wr_refused,
    input wire ssa_pkg::ssa_mode_t cur_mode,
    input wire logic exec_world,
    input wire logic world_select_bit,
    input wire logic req_is_dma,
    input wire logic req_is_walk,
    input wire logic walk_miss_security,
    input wire logic mmu_en_secure,
    input wire logic pagetable_security_bit,
    input wire logic request_security,
    input wire logic location_security,
    input wire logic hw_bank_select,
    input wire logic cache_addr_match,
    input wire logic cache_stored_tag,
    input wire logic cache_hit,
    input wire logic bus_security_signal,
    input wire logic region_is_secure,
    input wire logic bus_req,
    input wire logic access_denied
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    // ****************************************************************
    // attribute checks
    // ****************************************************************
    a_world_derive: assert property (exec_world == (world_select_bit &&
        cur_mode != `SSA_MODE_MON)) else $error("world wrong");
    a_core_req: assert property (!req_is_dma && !req_is_walk |->
        request_security == exec_world) else $error("core req wrong");
    a_walk_loc: assert property (req_is_walk |->
        location_security == walk_miss_security) else $error("walk wrong");
    a_loc_mmu_off: assert property (!mmu_en_secure && !req_is_walk |->
        location_security == request_security) else $error("loc off wrong");
    a_loc_mmu_on: assert property (mmu_en_secure && !req_is_walk |->
        location_security == (request_security | pagetable_security_bit))
        else $error("loc on wrong");
    a_hit_tag: assert property (cache_hit == (cache_addr_match &&
        cache_stored_tag == location_security)) else $error("hit wrong");
    a_bus_ident: assert property (bus_security_signal ==
        location_security) else $error("bus id wrong");
    a_hw_bank: assert property (hw_bank_select == request_security)
        else $error("bank wrong");
    a_deny_secure: assert property (access_denied ==
        (bus_req && region_is_secure && exec_world))
        else $error("deny wrong");
    a_cfg_refuse: assert property (reg_wr && reg_addr <= 4'h3 |=>
        reg_wr_refused == $past(exec_world || cur_mode == `SSA_MODE_USR))
        else $error("refuse wrong");
    a_cfg_locked: assert property (reg_wr && reg_addr == 4'h0 &&
        exec_world |=> $stable(world_select_bit)) else $error("cfg changed");
    c_walk: cover property (req_is_walk && location_security);
    c_refused: cover property (reg_wr_refused);
    c_denied: cover property (access_denied);
endmodule : ssa_props

// File: test/ssa_top_tb.sv
`include "ssa_defines.svh"

module ssa_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, nrst, reg_wr, reg_rd, reg_wr_refused, mode_load, leak;
    ssa_pkg::ssa_addr_t reg_addr;
    ssa_pkg::ssa_word_t reg_wdata, reg_rdata, d;
    ssa_pkg::ssa_mode_t mode_next, cur_mode;
    logic exec_world, world_select_bit, req_is_dma, req_is_walk;
    logic walk_miss_security, mmu_en_secure, pagetable_security_bit;
    logic request_security, location_security, sw_bank_select;
    logic hw_bank_select, tlb_fill, tlb_entry_world_id, tlb_fill_out;
    logic cache_line_world_tag, cache_addr_match, cache_stored_tag, cache_hit;
    logic bus_req, region_is_secure, bus_security_signal, bus_grant;
    logic access_denied, dma_security_bit, itcm_access_security;
    logic dtcm_access_security, irq_req, fiq_req, precise_abort;
    logic imprecise_abort, irq_to_monitor, fiq_to_monitor;
    logic precise_abort_to_monitor, imprecise_abort_to_monitor;
    logic mask_wr, async_abort_mask_in, fast_irq_mask_in;
    logic async_abort_mask, fast_irq_mask;
    int err_count, total_checks, cyc;
    ssa_top u_ssa_top (.*);
    ssa_bus_model u_ssa_bus_model (.*);
    // ****************************************************************
    // bus and compare tasks
    // ****************************************************************
    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task wr(input logic [3:0] a, input logic [31:0] v);
        @(posedge clk); reg_addr <= a; reg_wdata <= v; reg_wr <= 1'h1;
        @(posedge clk); reg_wr <= 1'h0; #1;
    endtask : wr
    task rd(input logic [3:0] a);
        @(posedge clk); reg_addr <= a; reg_rd <= 1'h1;
        @(posedge clk); reg_rd <= 1'h0; #1; d = reg_rdata;
    endtask : rd
    task mode(input logic [4:0] m);
        @(posedge clk); mode_next <= m; mode_load <= 1'h1;
        @(posedge clk); mode_load <= 1'h0; #1;
    endtask : mode
    task mask_pulse;
        @(posedge clk); mask_wr <= 1'h1; async_abort_mask_in <= 1'h1;
        fast_irq_mask_in <= 1'h1;
        @(posedge clk); mask_wr <= 1'h0; #1;
    endtask : mask_pulse
    task report_and_stop;
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : report_and_stop
    // ****************************************************************
    // scenarios
    // ****************************************************************
    task t_reset;
        chk("cur_mode", `SSA_MODE_SVC, cur_mode);
        chk("exec_world", 0, exec_world);
        rd(4'h5); chk("mode_reg", `SSA_MODE_SVC, d);
        rd(4'h0); chk("cfg_reg", 0, d);
        $display("reset test done");
    endtask : t_reset
    task t_regs;
        wr(4'h1, 32'h00040000); wr(4'h2, 32'h1); wr(4'h3, 32'h1);
        chk("dma_bit", 1, dma_security_bit);
        chk("itcm", 1, itcm_access_security);
        chk("dtcm", 1, dtcm_access_security);
        rd(4'h1); chk("nsacc_reg", 32'h00040000, d);
        wr(4'h4, 32'hFFFFFFFF); rd(4'h4); chk("dbg_sec", 0, d[18]);
        rd(4'hF); chk("unmapped", 0, d);
        $display("register test done");
    endtask : t_regs
    task t_world;
        wr(4'h0, 32'h1); chk("world_ns", 1, exec_world);
        chk("sw_bank", 1, sw_bank_select);
        rd(4'h4); chk("dbg_ns", 1, d[18]);
        wr(4'h0, 32'h0); chk("refused_ns", 1, reg_wr_refused);
        mode(`SSA_MODE_MON); chk("mon_world", 0, exec_world);
        chk("wsb_mon", 1, world_select_bit);
        chk("sw_bank_mon", 1, sw_bank_select);
        wr(4'h0, 32'h0); chk("accepted", 0, reg_wr_refused);
        mode(`SSA_MODE_USR); wr(4'h0, 32'h1);
        chk("refused_usr", 1, reg_wr_refused);
        mode(`SSA_MODE_SVC);
        $display("world test done");
    endtask : t_world
    task t_route;
        @(posedge clk); irq_req <= 1'h1; fiq_req <= 1'h1;
        precise_abort <= 1'h1; imprecise_abort <= 1'h1;
        for (int i = 1; i < 4; i++) begin
            wr(4'h0, 32'h1 << i);
            chk("irq_mon", i == 1, irq_to_monitor);
            chk("fiq_mon", i == 2, fiq_to_monitor);
            chk("pab_mon", i == 3, precise_abort_to_monitor);
            chk("iab_mon", i == 3, imprecise_abort_to_monitor);
        end
        $display("routing test done");
    endtask : t_route
    task t_mask;
        mode(`SSA_MODE_MON); wr(4'h0, 32'h31); mode(`SSA_MODE_SVC);
        mask_pulse; chk("masks_locked", 0, {async_abort_mask, fast_irq_mask});
        mode(`SSA_MODE_MON); mask_pulse;
        chk("masks_open", 3, {async_abort_mask, fast_irq_mask});
        wr(4'h0, 32'h0); mode(`SSA_MODE_SVC);
        $display("mask test done");
    endtask : t_mask
    task t_attr(input logic w);
        logic rq, loc, dn;
        for (int i = 0; i < 512; i++) begin
            @(posedge clk);
            {cache_addr_match, cache_stored_tag, bus_req, region_is_secure,
             pagetable_security_bit, mmu_en_secure, walk_miss_security,
             req_is_walk, req_is_dma} <= i[8:0];
            tlb_fill <= ~i[0];
            #1;
            rq = req_is_dma ? 1'h1 : req_is_walk ? walk_miss_security : w;
            loc = req_is_walk ? walk_miss_security : !mmu_en_secure ? rq :
                  (rq | pagetable_security_bit);
            dn = bus_req & region_is_secure & w;
            chk("tlb_id", rq, tlb_entry_world_id);
            chk("tlb_fill", tlb_fill, tlb_fill_out);
            chk("req_sec", rq, request_security);
            chk("hw_bank", rq, hw_bank_select);
            chk("loc_sec", loc, location_security);
            chk("bus_id", loc, bus_security_signal);
            chk("line_tag", loc, cache_line_world_tag);
            chk("hit", cache_addr_match & (cache_stored_tag == loc),
                cache_hit);
            chk("denied", dn, access_denied);
            chk("grant", bus_req & !dn, bus_grant);
        end
        $display("attribute test done");
    endtask : t_attr
    // ****************************************************************
    // clock, reset, sequence, timeout
    // ****************************************************************
    initial begin
        clk = 1'h0;
        forever #12.5 clk = ~clk;
    end
    initial begin
        cyc = 0;
        forever @(posedge clk) begin
            cyc++;
            if (cyc == 6000) begin
                err_count++;
                report_and_stop;
            end
        end
    end
    initial begin
        {nrst, reg_wr, reg_rd, mode_load, req_is_dma, req_is_walk} = '0;
        {walk_miss_security, mmu_en_secure, pagetable_security_bit} = '0;
        {tlb_fill, cache_addr_match, cache_stored_tag, bus_req} = '0;
        {region_is_secure, irq_req, fiq_req, precise_abort} = '0;
        {imprecise_abort, mask_wr, async_abort_mask_in} = '0;
        fast_irq_mask_in = 1'h0;
        reg_addr = '0; reg_wdata = '0; mode_next = `SSA_MODE_SVC;
        err_count = 0; total_checks = 0;
        repeat (20) @(posedge clk);
        nrst <= 1'h1; #1;
        t_reset; t_regs; t_world; t_route; t_mask;
        wr(4'h1, 32'h00040000); t_attr(1'h0);
        wr(4'h0, 32'h1); t_attr(1'h1);
        chk("bus_leak", 0, leak);
        report_and_stop;
    end
endmodule : ssa_top_tb

bind ssa_top ssa_props u_ssa_props (.*);
